/* inc/tlb_cache_pkg.sv */
/*
  Constants for the backup translation tag store and data cache tag store.
  Assumes a single 50 MHz core clock shared with the core and port controller.
*/
package tlb_cache_pkg;
  // ****************************************************
  // Geometry
  // ****************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int TAG_SETS = 128;
  localparam int IDX_W = 7;
  localparam int XTAG_W = 14;
  localparam int CTAG_W = 16;
  localparam int RAM_ADDR_W = 11;
  localparam int PTE_DEPTH = 512;
  localparam int PTE_IDX_W = 9;
  localparam int DATA_DEPTH = 2048;
  localparam int PFN_W = 21;
  localparam int PAGE_OFS_W = 9;
  // ****************************************************
  // Address fields
  // ****************************************************
  localparam int SPACE_BIT = 31;
  localparam int XTAG_HI = 30;
  localparam int XTAG_LO = 17;
  localparam int XRAM_HI = 16;
  localparam int XRAM_LO = 9;
  localparam int XSEL_HI = 10;
  localparam int XSEL_LO = 9;
  localparam int IO_BIT = 29;
  localparam int CTAG_HI = 28;
  localparam int CTAG_LO = 13;
  localparam int CRAM_HI = 12;
  localparam int CRAM_LO = 2;
  localparam int OCT_HI = 5;
  localparam int OCT_LO = 4;
  localparam int LW_HI = 3;
  localparam int LW_LO = 2;
  // ****************************************************
  // Reset values and commands
  // ****************************************************
  localparam logic [3:0] VALID_RST = 4'h0;
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_READ_PTE = 4'h1;
  localparam logic [3:0] CMD_READ_DATA = 4'h2;
  localparam logic [3:0] CMD_WRITE = 4'h3;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_XOUT = 5'h02,
    ST_PTE = 5'h04,
    ST_FILL = 5'h08,
    ST_WR = 5'h10
  } state_t;
endpackage : tlb_cache_pkg

/* tb/port_ctrl_model.sv */
/*
  Behavioural port controller: answers each memory longword with one ack pulse.
  Assumes the block holds flag and command until the last ack and each longword address until its ack.
*/
`timescale 1ns/1ps
module port_ctrl_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Request side
  input wire logic memory_request_flag_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [3:0] delay_i,
  // Answer side
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  // ****************************************************
  // Memory contents and answer timing
  // ****************************************************
  logic [3:0] wait_q;

  function automatic logic [31:0] word_at(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'h5a3c_0f00;
  endfunction : word_at

  // Drives just after the falling edge; data toggles when not answering
  always @(negedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 32'h0000_0000;
      wait_q <= 4'h0;
    end else if (mem_ack_o) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      wait_q <= 4'h0;
    end else if (memory_request_flag_i && wait_q >= delay_i) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= word_at(mem_addr_i);
    end else begin
      wait_q <= memory_request_flag_i ? wait_q + 4'h1 : 4'h0;
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule : port_ctrl_model

/* tb/testbench.sv */
/*
  Self-checking bench for the translation and cache tag block.
  Assumes the port controller model above and the package constants.
*/
`timescale 1ns/1ps
module testbench;
  import tlb_cache_pkg::*;
  // ****************************************************
  // Signals
  // ****************************************************
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic req_virt_i = 1'b0;
  logic req_write_i = 1'b0;
  logic snoop_i = 1'b0;
  logic [31:0] shared_data_addr_bus_i = 32'h0000_0000;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic [31:0] snoop_addr_i = 32'h0000_0000;
  logic [31:0] pt_base_i = 32'h0010_0000;
  logic [IDX_W-1:0] tag_index_bus_i = '0;
  logic [3:0] delay = 4'h2;
  logic busy_o, done_o, xlate_hit_o, cache_hit_o, phys_valid_o, mem_ack_i;
  logic shared_data_addr_bus_oe_o, memory_request_flag_o;
  logic [RAM_ADDR_W-1:0] ram_addr_o, got_ram;
  logic [31:0] phys_addr_o, shared_data_addr_bus_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [3:0] mem_cmd_o;
  logic [31:0] got_bus, got_pa;
  logic got_oe, got_pv, got_xhit, got_chit;
  logic [31:0] q_addr[$];
  logic [31:0] q_wd[$];
  logic [3:0] q_cmd[$];
  int miscompares = 0;
  int check_count = 0;
  int lat;

  always #10 core_clk_i = ~core_clk_i;

  xlate_cache_tags DUT (.core_clk_i, .rst_i, .req_i, .req_virt_i, .req_write_i,
    .shared_data_addr_bus_i, .tag_index_bus_i, .wdata_i, .pt_base_i, .busy_o, .done_o,
    .xlate_hit_o, .cache_hit_o, .ram_addr_o, .phys_valid_o, .phys_addr_o,
    .shared_data_addr_bus_o, .shared_data_addr_bus_oe_o, .memory_request_flag_o,
    .mem_cmd_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .snoop_i,
    .snoop_addr_i);

  port_ctrl_model partner (.core_clk_i, .rst_i, .memory_request_flag_i(memory_request_flag_o),
    .mem_addr_i(mem_addr_o), .delay_i(delay), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i));

  // Log of every longword the port controller completes
  always @(posedge core_clk_i) begin
    if (mem_ack_i && memory_request_flag_o) begin
      q_addr.push_back(mem_addr_o);
      q_cmd.push_back(mem_cmd_o);
      q_wd.push_back(mem_wdata_o);
    end
  end

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'h5a3c_0f00;
  endfunction : mem_word

  task automatic final_report;
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // One core request: pulse, capture answer, wait for the block to go idle
  task automatic do_req(input logic virt, input logic wr, input logic [31:0] a,
                        input logic [31:0] wd);
    int n;
    n = 0;
    q_addr.delete();
    q_cmd.delete();
    q_wd.delete();
    req_i = 1'b1;
    req_virt_i = virt;
    req_write_i = wr;
    shared_data_addr_bus_i = a;
    wdata_i = wd;
    tag_index_bus_i = virt ? {a[31], a[16:11]} : a[12:6];
    @(negedge core_clk_i);
    req_i = 1'b0;
    got_xhit = xlate_hit_o;
    got_chit = cache_hit_o;
    got_ram = ram_addr_o;
    lat = 1;
    while (done_o !== 1'b1 && lat < 200) begin
      @(negedge core_clk_i);
      lat++;
    end
    check({31'h0, done_o}, 32'h1, "answer");
    got_bus = shared_data_addr_bus_o;
    got_oe = shared_data_addr_bus_oe_o;
    got_pv = phys_valid_o;
    got_pa = phys_addr_o;
    while ((busy_o !== 1'b0 || memory_request_flag_o !== 1'b0) && n < 200) begin
      @(negedge core_clk_i);
      n++;
    end
    check({busy_o, memory_request_flag_o}, 0, "idle");
    @(negedge core_clk_i);
  endtask : do_req

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic read_fill_scn(input logic [31:0] a);
    logic [1:0] lw;
    do_req(1'b0, 1'b0, a, 32'h0);
    check(got_chit, 0, "miss");
    check(got_ram, a[12:2], "ram address");
    check(q_cmd.size(), 4, "fill count");
    for (int w = 0; w < 4; w++) begin
      lw = a[3:2] + w[1:0];
      check(q_addr[w][31:2], {2'b00, a[31:4], lw}, "fill order");
      check(q_cmd[w], CMD_READ_DATA, "fill command");
    end
    check(got_bus, mem_word(a), "missed word");
    do_req(1'b0, 1'b0, a + 32'h4, 32'h0);
    check({got_chit, got_oe}, 2'b11, "hit");
    check(lat, 1, "hit latency");
    check(got_bus, mem_word(a + 32'h4), "hit data");
    check(q_cmd.size(), 0, "no memory");
  endtask : read_fill_scn

  task automatic io_write_scn(input logic [31:0] a);
    do_req(1'b0, 1'b0, a | 32'h2000_0000, 32'h0);
    check(got_chit, 0, "io miss");
    check(q_cmd.size(), 1, "io reads");
    check(got_bus, mem_word(a | 32'h2000_0000), "io data");
    do_req(1'b0, 1'b1, a, 32'hc0de_1234);
    check(q_cmd[0], CMD_WRITE, "write command");
    check(q_addr[0][31:2], a[31:2], "write address");
    check(q_wd[0], 32'hc0de_1234, "write data");
    do_req(1'b0, 1'b1, a ^ 32'h0000_2000, 32'h1111_2222);
    check(got_chit, 0, "write miss");
    check(q_cmd.size(), 1, "write miss memory");
    do_req(1'b0, 1'b0, a, 32'h0);
    check(got_chit, 1, "still cached");
    check(got_bus, 32'hc0de_1234, "written data");
  endtask : io_write_scn

  task automatic snoop_scn(input logic [31:0] a);
    delay = 4'h5;
    snoop_i = 1'b1;
    snoop_addr_i = a + 32'h30;
    @(negedge core_clk_i);
    snoop_i = 1'b0;
    do_req(1'b0, 1'b0, a, 32'h0);
    check(got_chit, 0, "snooped block");
    do_req(1'b0, 1'b0, a + 32'h10, 32'h0);
    check(q_cmd.size(), 4, "second octaword");
    do_req(1'b0, 1'b0, a, 32'h0);
    check(got_chit, 0, "other octaword invalid");
  endtask : snoop_scn

  task automatic xlate_scn;
    logic [31:0] va[7];
    logic eh[7];
    logic [31:0] pte;
    va = '{32'h8006_4200, 32'h8006_4200, 32'h8006_4400, 32'h8006_4400,
           32'h8004_4200, 32'h8006_4200, 32'h8006_4400};
    eh = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 7; i++) begin
      pte = pt_base_i + {7'h00, va[i][31:9], 2'b00};
      do_req(1'b1, 1'b0, va[i], 32'h0);
      check(got_xhit, eh[i], "backup hit");
      check(got_ram, {2'b00, va[i][31], va[i][16:9]}, "pte ram address");
      check(got_pv, 1, "translation valid");
      check(got_pa, ((mem_word(pte) << 9) & 32'h3fff_fe00) | va[i][8:0], "physical");
      if (eh[i]) begin
        check(lat, 2, "backup latency");
        check(q_cmd.size(), 0, "no pte read");
      end else begin
        check(q_cmd.size(), 1, "pte reads");
        check(q_cmd[0], CMD_READ_PTE, "pte command");
        check(q_addr[0][31:2], pte[31:2], "pte address");
      end
    end
  endtask : xlate_scn

  // ****************************************************
  // Main sequence and watchdog
  // ****************************************************
  initial begin
    repeat (12) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    check({busy_o, done_o, memory_request_flag_o}, 0, "reset state");
    read_fill_scn(32'h0001_2344);
    io_write_scn(32'h0001_2344);
    snoop_scn(32'h0001_2344);
    xlate_scn();
    final_report();
  end

  initial begin
    #400000;
    miscompares++;
    final_report();
  end
endmodule : testbench

/* verilog/tag_match.sv */
/*
  Tag compare for one tag entry with optional parity check.
  Assumes stored parity is even over the field and its parity bit.
*/
`timescale 1ns/1ps
module tag_match #(
  parameter int W = 14,
  parameter bit CHECK_PAR = 1'b0
) (
  // Stored entry
  input wire logic [W-1:0] stored_i,
  input wire logic addr_par_i,
  input wire logic [3:0] valid_i,
  input wire logic valid_par_i,
  // Probe
  input wire logic [W-1:0] probe_i,
  input wire logic [1:0] sel_i,
  // Result
  output logic match_o,
  output logic hit_o
);
  // ****************************************************
  // Compare
  // ****************************************************
  wire par_ok = !CHECK_PAR || ((^{stored_i, addr_par_i}) == 1'b0 &&
    (^{valid_i, valid_par_i}) == 1'b0);
  assign match_o = (stored_i == probe_i) && par_ok;
  assign hit_o = match_o && valid_i[sel_i];
endmodule : tag_match

/* verilog/xlate_cache_tags.sv */
/*
  Backup translation tags, data cache tags, PTE and data storage, fill control.
  Assumes the core keeps tag_index_bus_i consistent with the address and
  the port controller answers each longword with one mem_ack_i pulse.
*/
// Notes on behaviour
// - Backup buffer holds 512 entries as 128 blocks of four longwords.
// - Each translation tag keeps address bits 30:17 and four valid bits.
// - Translation lookup indexes tags with bits 31 and 16:11 on index lines.
// - Translation hit needs tag match and the addressed entry's valid bit.
// - Translation RAM address from bits 31, 16:9 driven in compare cycle.
// - Bits 10:9 pick the entry within the block.
// - Backup hit loads first-level buffer; translation appears one cycle later.
// - Double miss reads one page table longword, filling both buffers.
// - Tag change on fill leaves only the filled entry valid.
// - Data cache is 8K bytes, 128 blocks of four octawords, one tag each.
// - Cache tag keeps bits 28:13 plus parity, four valids plus parity.
// - Physical lookup indexes cache tags with bits 12:6.
// - Cache hit needs match, octaword valid, bit 29 clear.
// - Cache RAM address bits 12:2 driven in compare cycle even on miss.
// - Read hit drives data; writes go to memory and to cache on hit.
// - Read miss reads missed longword first, answers, then three more; with bit 29 set it reads the missed longword only.
// - Fill rewrites tag, marks filled octaword valid, others invalid.
// - Write miss touches no cache tag or data.
// - Snooped write to a cached block invalidates all four octawords.
// - Entry supplies 21-bit frame number for a 512-byte page.
// - Memory references raise the request flag with a command code.
`timescale 1ns/1ps
module xlate_cache_tags
  import tlb_cache_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Core request
  input wire logic req_i,
  input wire logic req_virt_i,
  input wire logic req_write_i,
  input wire logic [31:0] shared_data_addr_bus_i,
  input wire logic [IDX_W-1:0] tag_index_bus_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] pt_base_i,
  // Core answer
  output logic busy_o,
  output logic done_o,
  output logic xlate_hit_o,
  output logic cache_hit_o,
  output logic [RAM_ADDR_W-1:0] ram_addr_o,
  output logic phys_valid_o,
  output logic [31:0] phys_addr_o,
  output logic [31:0] shared_data_addr_bus_o,
  output logic shared_data_addr_bus_oe_o,
  // Port controller
  output logic memory_request_flag_o,
  output logic [3:0] mem_cmd_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic snoop_i,
  input wire logic [31:0] snoop_addr_i
);
  // ****************************************************
  // Storage
  // ****************************************************
  logic [31:0] pte_mem [PTE_DEPTH];
  logic [31:0] data_mem [DATA_DEPTH];
  logic [XTAG_W-1:0] xtag_mem [TAG_SETS];
  logic [3:0] xvalid [TAG_SETS];
  logic [CTAG_W-1:0] ctag_mem [TAG_SETS];
  logic ctag_par [TAG_SETS];
  logic [3:0] cvalid [TAG_SETS];
  logic cvpar [TAG_SETS];

  state_t state_q;
  logic [31:0] addr_q;
  logic [IDX_W-1:0] idx_q;
  logic [1:0] word_q;
  logic [1:0] cnt_q;
  logic [22:0] fl_vpn_q;
  logic [PFN_W-1:0] fl_pfn_q;
  logic fl_v_q;
  logic done_q, xhit_q, chit_q, pvalid_q, oe_q, mreq_q, busy_q;
  logic [RAM_ADDR_W-1:0] ram_addr_q;
  logic [31:0] paddr_q, bus_q, maddr_q, mwdata_q;
  logic [3:0] mcmd_q;

  // ****************************************************
  // Lookup
  // ****************************************************
  wire [31:0] a = shared_data_addr_bus_i;
  wire [PTE_IDX_W-1:0] pte_a = {a[SPACE_BIT], a[XRAM_HI:XRAM_LO]};
  wire [RAM_ADDR_W-1:0] xram_a = {2'b00, pte_a};
  wire [RAM_ADDR_W-1:0] cram_a = a[CRAM_HI:CRAM_LO];
  wire [31:0] pte_rd = pte_mem[pte_a];
  wire [31:0] data_rd = data_mem[cram_a];
  wire xhit_raw, chit_raw, smatch;
  wire [IDX_W-1:0] sidx = snoop_addr_i[CRAM_HI:OCT_HI+1];

  tag_match #(.W(XTAG_W), .CHECK_PAR(1'b0)) u_xmatch (
    .stored_i(xtag_mem[tag_index_bus_i]),
    .addr_par_i(1'b0),
    .valid_i(xvalid[tag_index_bus_i]),
    .valid_par_i(1'b0),
    .probe_i(a[XTAG_HI:XTAG_LO]),
    .sel_i(a[XSEL_HI:XSEL_LO]),
    .match_o(),
    .hit_o(xhit_raw)
  );
  tag_match #(.W(CTAG_W), .CHECK_PAR(1'b1)) u_cmatch (
    .stored_i(ctag_mem[tag_index_bus_i]),
    .addr_par_i(ctag_par[tag_index_bus_i]),
    .valid_i(cvalid[tag_index_bus_i]),
    .valid_par_i(cvpar[tag_index_bus_i]),
    .probe_i(a[CTAG_HI:CTAG_LO]),
    .sel_i(a[OCT_HI:OCT_LO]),
    .match_o(),
    .hit_o(chit_raw)
  );
  tag_match #(.W(CTAG_W), .CHECK_PAR(1'b0)) u_smatch (
    .stored_i(ctag_mem[sidx]),
    .addr_par_i(1'b0),
    .valid_i(cvalid[sidx]),
    .valid_par_i(1'b0),
    .probe_i(snoop_addr_i[CTAG_HI:CTAG_LO]),
    .sel_i(2'b00),
    .match_o(smatch),
    .hit_o()
  );

  wire chit = chit_raw && !a[IO_BIT];
  wire take = (state_q == ST_IDLE) && req_i;
  wire take_x = take && req_virt_i;
  wire take_p = take && !req_virt_i;
  wire ack_pte = (state_q == ST_PTE) && mem_ack_i;
  wire ack_fill = (state_q == ST_FILL) && mem_ack_i;
  wire io_q = addr_q[IO_BIT];
  wire wr_hit = take_p && req_write_i && chit;
  wire data_we = wr_hit || (ack_fill && !io_q);
  wire [RAM_ADDR_W-1:0] data_wa = wr_hit ? cram_a : {addr_q[CRAM_HI:OCT_LO], word_q};
  wire [31:0] data_wd = wr_hit ? wdata_i : mem_rdata_i;
  wire ctag_we = ack_fill && !io_q && (cnt_q == 2'h0);
  wire [IDX_W-1:0] fidx = addr_q[CRAM_HI:OCT_HI+1];
  wire [3:0] oct_one = 4'h1 << addr_q[OCT_HI:OCT_LO];
  wire [3:0] pte_one = 4'h1 << addr_q[XSEL_HI:XSEL_LO];
  wire [PTE_IDX_W-1:0] pte_wa = {addr_q[SPACE_BIT], addr_q[XRAM_HI:XRAM_LO]};
  wire xtag_change = xtag_mem[idx_q] != addr_q[XTAG_HI:XTAG_LO];
  wire [1:0] word_nx = word_q + 2'h1;
  wire [31:0] pte_addr = pt_base_i + {7'h00, a[31:PAGE_OFS_W], 2'b00};
  wire snoop_hit = snoop_i && smatch && (cvalid[sidx] != 4'h0);

  // ****************************************************
  // Array writes
  // ****************************************************
  always_ff @(posedge core_clk_i) begin
    if (ack_pte) begin
      pte_mem[pte_wa] <= mem_rdata_i;
      xtag_mem[idx_q] <= addr_q[XTAG_HI:XTAG_LO];
    end
    if (data_we) begin
      data_mem[data_wa] <= data_wd;
    end
    if (ctag_we) begin
      ctag_mem[fidx] <= addr_q[CTAG_HI:CTAG_LO];
      ctag_par[fidx] <= ^addr_q[CTAG_HI:CTAG_LO];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < TAG_SETS; i++) begin
        xvalid[i] <= VALID_RST;
        cvalid[i] <= VALID_RST;
        cvpar[i] <= 1'b0;
      end
    end else begin
      if (ack_pte) begin
        xvalid[idx_q] <= xtag_change ? pte_one : (xvalid[idx_q] | pte_one);
      end
      if (ctag_we) begin
        cvalid[fidx] <= oct_one;
        cvpar[fidx] <= 1'b1;
      end
      if (snoop_hit) begin
        cvalid[sidx] <= VALID_RST;
        cvpar[sidx] <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Control
  // ****************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      addr_q <= 32'h0000_0000;
      idx_q <= 7'h00;
      word_q <= 2'h0;
      cnt_q <= 2'h0;
      fl_vpn_q <= 23'h00_0000;
      fl_pfn_q <= 21'h00_0000;
      fl_v_q <= 1'b0;
      done_q <= 1'b0;
      xhit_q <= 1'b0;
      chit_q <= 1'b0;
      pvalid_q <= 1'b0;
      oe_q <= 1'b0;
      mreq_q <= 1'b0;
      busy_q <= 1'b0;
      ram_addr_q <= 11'h000;
      paddr_q <= 32'h0000_0000;
      bus_q <= 32'h0000_0000;
      maddr_q <= 32'h0000_0000;
      mwdata_q <= 32'h0000_0000;
      mcmd_q <= CMD_IDLE;
    end else begin
      done_q <= 1'b0;
      oe_q <= 1'b0;
      pvalid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req_i) begin
            busy_q <= 1'b1;
            addr_q <= a;
            idx_q <= tag_index_bus_i;
            word_q <= a[LW_HI:LW_LO];
            cnt_q <= 2'h0;
            if (req_virt_i) begin
              ram_addr_q <= xram_a;
              xhit_q <= xhit_raw;
              chit_q <= 1'b0;
              if (xhit_raw) begin
                fl_vpn_q <= a[31:PAGE_OFS_W];
                fl_pfn_q <= pte_rd[PFN_W-1:0];
                fl_v_q <= 1'b1;
                state_q <= ST_XOUT;
              end else begin
                mreq_q <= 1'b1;
                mcmd_q <= CMD_READ_PTE;
                maddr_q <= pte_addr;
                state_q <= ST_PTE;
              end
            end else begin
              ram_addr_q <= cram_a;
              chit_q <= chit;
              xhit_q <= 1'b0;
              if (req_write_i) begin
                mreq_q <= 1'b1;
                mcmd_q <= CMD_WRITE;
                maddr_q <= a;
                mwdata_q <= wdata_i;
                state_q <= ST_WR;
              end else if (chit) begin
                bus_q <= data_rd;
                busy_q <= 1'b0;
                oe_q <= 1'b1;
                done_q <= 1'b1;
              end else begin
                mreq_q <= 1'b1;
                mcmd_q <= CMD_READ_DATA;
                maddr_q <= a;
                state_q <= ST_FILL;
              end
            end
          end
        end
        ST_XOUT: begin
          paddr_q <= {2'b00, fl_pfn_q, addr_q[PAGE_OFS_W-1:0]};
          pvalid_q <= fl_v_q && (fl_vpn_q == addr_q[31:PAGE_OFS_W]);
          busy_q <= 1'b0;
          done_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        ST_PTE: begin
          if (mem_ack_i) begin
            mreq_q <= 1'b0;
            mcmd_q <= CMD_IDLE;
            fl_vpn_q <= addr_q[31:PAGE_OFS_W];
            fl_pfn_q <= mem_rdata_i[PFN_W-1:0];
            fl_v_q <= 1'b1;
            state_q <= ST_XOUT;
          end
        end
        ST_FILL: begin
          if (mem_ack_i) begin
            if (cnt_q == 2'h0) begin
              bus_q <= mem_rdata_i;
              oe_q <= 1'b1;
              done_q <= 1'b1;
            end
            if (cnt_q == 2'h3 || io_q) begin
              busy_q <= 1'b0;
              mreq_q <= 1'b0;
              mcmd_q <= CMD_IDLE;
              state_q <= ST_IDLE;
            end else begin
              cnt_q <= cnt_q + 2'h1;
              word_q <= word_nx;
              maddr_q <= {addr_q[31:OCT_LO], word_nx, 2'b00};
            end
          end
        end
        ST_WR: begin
          if (mem_ack_i) begin
            busy_q <= 1'b0;
            mreq_q <= 1'b0;
            mcmd_q <= CMD_IDLE;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign xlate_hit_o = xhit_q;
  assign cache_hit_o = chit_q;
  assign ram_addr_o = ram_addr_q;
  assign phys_valid_o = pvalid_q;
  assign phys_addr_o = paddr_q;
  assign shared_data_addr_bus_o = bus_q;
  assign shared_data_addr_bus_oe_o = oe_q;
  assign memory_request_flag_o = mreq_q;
  assign mem_cmd_o = mcmd_q;
  assign mem_addr_o = maddr_q;
  assign mem_wdata_o = mwdata_q;

  // ****************************************************
  // Checks
  // ****************************************************
  chk_xlate_ram_addr: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take_x |=> ram_addr_q == {2'b00, $past(a[SPACE_BIT]), $past(a[XRAM_HI:XRAM_LO])})
    else $error("translation RAM address wrong");
  chk_xlate_delay: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take_x && xhit_raw |=> !done_q ##1 (done_q && pvalid_q))
    else $error("backup hit translation not one cycle later");
  chk_io_no_hit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take_p && a[IO_BIT] |=> !chit_q)
    else $error("io space reference hit");
  chk_read_hit_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take_p && !req_write_i && chit |=> oe_q && done_q && !mreq_q)
    else $error("read hit not driven");
  chk_write_to_mem: assert property (@(posedge core_clk_i) disable iff (rst_i)
    take_p && req_write_i |=> mreq_q && mcmd_q == CMD_WRITE && maddr_q == $past(a))
    else $error("write not sent to memory");
  chk_fill_first_word: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_fill && cnt_q == 2'h0 |=> done_q && oe_q && bus_q == $past(mem_rdata_i))
    else $error("missed longword not returned first");
  chk_fill_valid_one: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctag_we && !snoop_hit |=> cvalid[$past(fidx)] == $past(oct_one))
    else $error("fill valid bits wrong");
  chk_pte_retag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_pte && xtag_change |=> xvalid[$past(idx_q)] == $past(pte_one))
    else $error("retagged block kept stale entries");
  chk_pte_single: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ack_pte |=> !mreq_q ##1 (pvalid_q && done_q))
    else $error("page table fill not single read");
  chk_snoop_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    snoop_hit |=> cvalid[$past(sidx)] == 4'h0)
    else $error("snooped block still valid");
endmodule : xlate_cache_tags
